/* File: dv/acs_host_bfm.sv */
// Host processor model: AHB-Lite master that programs the audio clock registers
`timescale 1ns/1ns
module acs_host_bfm
  import acs_pkg::*;
(
  // Clock
  input  wire logic        i_mclk,
  // Bus answer
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  // Bus request
  output logic             o_hsel,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  // Idle bus from time zero
  initial begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize  = HSIZE_WORD;
    o_hwdata = 32'hA5A5A5A5;
  end

  // One single word transfer; no latency assumed, the bench watchdog cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d, output logic [31:0] q);
    @(posedge i_mclk);
    o_hsel   <= 1'b1;
    o_htrans <= 2'h2;
    o_haddr  <= {22'h0, idx, 2'h0};
    o_hwrite <= wr;
    o_hsize  <= HSIZE_WORD;
    o_hwdata <= ~o_hwdata;  // Stale data phase value never lingers
    do @(posedge i_mclk); while (i_hready !== 1'b1);
    o_hsel   <= 1'b0;
    o_htrans <= 2'h0;
    o_hwdata <= {16'h0, d};  // Unused upper bits always zero
    do @(posedge i_mclk); while (i_hready !== 1'b1);
    q = i_hrdata;
  endtask

  // Plain register write
  task automatic write(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask

  // 32-bit parameter as low half then high half
  task automatic set32(input logic [7:0] lo_idx, input logic [31:0] v);
    write(lo_idx, v[15:0]);
    write(lo_idx + 8'h01, v[31:16]);
  endtask

  // Update bit cleared then set, so the device sees a rising edge
  task automatic apply(input logic triple);
    logic [15:0] d;
    d = 16'h0;
    d[CTRL_TRIPLE] = triple;
    write(IDX_CTRL, d);
    d[CTRL_UPD] = 1'b1;
    write(IDX_CTRL, d);
  endtask

  // Loop bandwidth; only legal pairs are sent
  task automatic set_bw(input logic [5:0] lo, input logic [5:0] hi);
    if (hi >= 6'd32 && hi <= 6'd42 && lo >= 6'd10 && lo <= hi - 6'd21) begin
      write(IDX_BW_HI, {10'h0, hi});
      write(IDX_BW_LO, {10'h0, lo});
    end
  endtask
endmodule // acs_host_bfm

/* File: dv/tb_top.sv */
// Self-checking bench for the audio clock parameter registers
`timescale 1ns/1ns
module tb_top;
  import acs_pkg::*;
  logic        i_mclk = 1'b0;            // 50 MHz clock
  logic        i_rst_n = 1'b0;           // Async reset, active low
  wire  logic  hsel, hwrite, hready, hresp, ld;
  wire  logic [31:0] haddr, hwdata, hrdata, r_num, r_den, fb, rf;
  wire  logic [1:0]  htrans;
  wire  logic [2:0]  hsize, mul;
  wire  logic [5:0]  bwl, bwu;
  wire  logic        trip;
  logic [31:0] d_num = 32'h0, d_den = 32'h0, d_fb = 32'h0, d_ref = 32'h0;  // Defaults in
  logic [5:0]  d_bwl = 6'h0, d_bwu = 6'h0;
  logic [31:0] m_num, m_den, m_fb, m_ref, e_num, e_den, v;  // Mirror and applied ratio
  logic [15:0] m_ctrl;
  logic [5:0]  m_bwl, m_bwu;
  logic [2:0]  m_mul;
  logic [31:0] rd_q[$];                  // Expected read data
  logic [63:0] ld_q[$];                  // Expected applied ratio per load pulse
  logic        rd_dp = 1'b0;             // Read data phase pending
  int          seed = 61;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #10 i_mclk = ~i_mclk;

  acs_regs u_acs_regs (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_dflt_num(d_num), .i_dflt_den(d_den), .i_dflt_bw_lower(d_bwl),
    .i_dflt_bw_upper(d_bwu), .i_dflt_fb_div(d_fb), .i_dflt_ref_div(d_ref), .o_ratio_num(r_num),
    .o_ratio_den(r_den), .o_ratio_load(ld), .o_loop_bw_lower(bwl), .o_loop_bw_upper(bwu),
    .o_lock_fb_div(fb), .o_lock_ref_div(rf), .o_out1_rate_multiple(mul), .o_triple_rate_enable(trip));

  acs_host_bfm u_acs_host_bfm (.i_mclk(i_mclk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

  // Word compare
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Applied ratio compare, numerator above denominator
  task automatic cmp_ratio(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    if (error_cnt == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Expected read value from the mirror; unmapped reads give zero
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    case (a)
      IDX_CTRL:   exp_rd = {16'h0, m_ctrl & 16'h0060};
      IDX_NUM_LO: exp_rd = {16'h0, m_num[15:0]};
      IDX_NUM_HI: exp_rd = {16'h0, m_num[31:16]};
      IDX_DEN_LO: exp_rd = {16'h0, m_den[15:0]};
      IDX_DEN_HI: exp_rd = {16'h0, m_den[31:16]};
      IDX_BW_LO:  exp_rd = {26'h0, m_bwl};
      IDX_BW_HI:  exp_rd = {26'h0, m_bwu};
      IDX_FBD_LO: exp_rd = {16'h0, m_fb[15:0]};
      IDX_FBD_HI: exp_rd = {16'h0, m_fb[31:16]};
      IDX_REF_LO: exp_rd = {16'h0, m_ref[15:0]};
      IDX_REF_HI: exp_rd = {16'h0, m_ref[31:16]};
      IDX_MUL:    exp_rd = {29'h0, m_mul};
      default:    exp_rd = 32'h0;
    endcase
  endfunction

  // Monitor: read completions and load pulses, each against the oldest note
  always @(posedge i_mclk) begin
    if (ld === 1'b1) begin
      // An unexpected pulse is forced to mismatch
      cmp_ratio({r_num, r_den}, ld_q.size() > 0 ? ld_q.pop_front() : ~{r_num, r_den});
    end
    if (!i_rst_n) begin
      rd_dp <= 1'b0;
    end else if (hready === 1'b1) begin
      if (rd_dp) cmp_word(hrdata, rd_q.size() > 0 ? rd_q.pop_front() : ~hrdata);
      if (rd_dp) cmp_word({31'h0, hresp}, 32'h0);
      rd_dp <= hsel & htrans[1] & ~hwrite;
    end
  end

  // Every index 0x30..0x3F, unmapped ones included
  task automatic read_all();
    logic [31:0] q;
    for (int i = 'h30; i <= 'h3F; i++) begin
      rd_q.push_back(exp_rd(8'(i)));
      u_acs_host_bfm.xfer(1'b0, 8'(i), 16'h0, q);
    end
  endtask

  // Outputs against mirror, sampled mid-cycle where settled
  task automatic chk_out();
    @(negedge i_mclk);
    cmp_ratio({r_num, r_den}, {e_num, e_den});
    cmp_word({20'h0, bwu, bwl}, {20'h0, m_bwu, m_bwl});
    cmp_word(fb, m_fb);
    cmp_word(rf, m_ref);
    cmp_word({28'h0, trip, mul}, {28'h0, m_ctrl[CTRL_TRIPLE], m_mul});
  endtask

  // Fresh random defaults, 12-cycle reset, mirror reloaded from defaults
  task automatic do_reset();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    d_num <= $random(seed);
    d_den <= $random(seed);
    d_fb  <= $random(seed);
    d_ref <= $random(seed);
    d_bwl <= 6'($random(seed));
    d_bwu <= 6'($random(seed));
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    {m_num, m_den, m_fb, m_ref, m_bwl, m_bwu} = {d_num, d_den, d_fb, d_ref, d_bwl, d_bwu};
    {e_num, e_den, m_ctrl, m_mul} = {d_num, d_den, 16'h0, 3'h0};
    chk_out();
    read_all();
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge i_mclk);
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial begin
    do_reset();
    // Staged ratio words leave the applied ratio alone
    m_num = $random(seed) | 32'h1;
    m_den = $random(seed) | 32'h10000;
    u_acs_host_bfm.set32(IDX_NUM_LO, m_num);
    u_acs_host_bfm.set32(IDX_DEN_LO, m_den);
    chk_out();
    read_all();
    // Rising update edge loads both, with triple rate set
    ld_q.push_back({m_num, m_den});
    u_acs_host_bfm.apply(1'b1);
    {e_num, e_den, m_ctrl} = {m_num, m_den, 16'h0060};
    repeat (3) @(posedge i_mclk);
    chk_out();
    // Update held high gives no further load
    u_acs_host_bfm.write(IDX_CTRL, 16'h0060);
    repeat (3) @(posedge i_mclk);
    chk_out();
    // Zero numerator keeps the old one, new denominator loads
    m_num = 32'h0;
    m_den = $random(seed) | 32'h1;
    u_acs_host_bfm.set32(IDX_NUM_LO, m_num);
    u_acs_host_bfm.set32(IDX_DEN_LO, m_den);
    ld_q.push_back({e_num, m_den});
    u_acs_host_bfm.apply(1'b0);
    {e_den, m_ctrl} = {m_den, 16'h0040};
    repeat (3) @(posedge i_mclk);
    chk_out();
    // Both parts zero: pulse still fires, running ratio kept
    m_den = 32'h0;
    u_acs_host_bfm.set32(IDX_DEN_LO, m_den);
    ld_q.push_back({e_num, e_den});
    u_acs_host_bfm.apply(1'b0);
    repeat (3) @(posedge i_mclk);
    chk_out();
    // Bandwidth boundary pairs
    for (int i = 0; i < 3; i++) begin
      m_bwu = i == 1 ? 6'd32 : 6'd42;
      m_bwl = i == 2 ? 6'd10 : m_bwu - 6'd21;
      u_acs_host_bfm.set_bw(m_bwl, m_bwu);
      chk_out();
    end
    // Manual lock dividers
    m_fb  = $random(seed);
    m_ref = $random(seed);
    u_acs_host_bfm.set32(IDX_FBD_LO, m_fb);
    u_acs_host_bfm.set32(IDX_REF_LO, m_ref);
    // Every output multiple code
    for (int i = 0; i < 8; i++) begin
      m_mul = 3'(i);
      u_acs_host_bfm.write(IDX_MUL, {13'h0, m_mul});
      chk_out();
    end
    read_all();
    // Second reset mid-run with new defaults
    do_reset();
    repeat (4) @(posedge i_mclk);
    v = 32'(ld_q.size());
    cmp_word(v, 32'h0);
    cmp_word(32'(rd_q.size()), 32'h0);
    complete_run();
  end
endmodule // tb_top

/* File: rtl/acs_ahb_front.sv */
// AHB-Lite slave front end: phase tracking and read wait state
`timescale 1ns/1ns
module acs_ahb_front
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  // AHB-Lite address phase
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic             i_hready,
  // AHB-Lite answer
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  // Register file side
  output logic                  o_wr_en,
  output logic                  o_rd_en,
  output logic [IDX_W-1:0]      o_idx
);
  // Registered and next state
  acs_fe_t st_reg;
  acs_fe_t st_next;
  // Address phase taken this edge
  logic    accept;
  // Legal word access inside the map window
  logic    word_ok;

  // Next phase; reads cost one wait so read data leaves a flop
  always_comb begin
    accept  = i_hsel & i_hready & i_htrans[1];
    word_ok = (i_hsize == HSIZE_WORD) && (i_haddr[31:10] == 22'h0) && (i_haddr[1:0] == 2'h0);
    st_next = st_reg;
    unique case (st_reg.st)
      FE_RD_WAIT: begin
        st_next.st = FE_RD_DONE;
      end
      FE_IDLE, FE_WR, FE_RD_DONE: begin
        st_next.st = FE_IDLE;
        // Pipelined address phase may arrive in any ready data phase
        if (accept) begin
          st_next.st  = i_hwrite ? FE_WR : FE_RD_WAIT;
          st_next.idx = word_ok ? i_haddr[IDX_LSB+IDX_W-1:IDX_LSB] : IDX_NONE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '{st: FE_IDLE, idx: IDX_NONE};
    end else begin
      st_reg <= st_next;
    end
  end

  // Answers; never an error
  assign o_hreadyout = (st_reg.st != FE_RD_WAIT);
  assign o_hresp     = 1'b0;
  assign o_wr_en     = (st_reg.st == FE_WR);
  assign o_rd_en     = (st_reg.st == FE_RD_WAIT);
  assign o_idx       = st_reg.idx;

  // Read wait lasts exactly one cycle
  rd_wait_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_rd_en |-> !o_hreadyout ##1 (o_hreadyout && !o_rd_en))
    else $error("read wait state not exactly one cycle");
endmodule // acs_ahb_front

/* File: rtl/acs_pkg.sv */
// Constants and types for the audio clock parameter registers
package acs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL    = 8'h31;
  localparam logic [7:0]  IDX_NUM_LO  = 8'h33;
  localparam logic [7:0]  IDX_NUM_HI  = 8'h34;
  localparam logic [7:0]  IDX_DEN_LO  = 8'h35;
  localparam logic [7:0]  IDX_DEN_HI  = 8'h36;
  localparam logic [7:0]  IDX_BW_LO   = 8'h39;
  localparam logic [7:0]  IDX_BW_HI   = 8'h3A;
  localparam logic [7:0]  IDX_FBD_LO  = 8'h3B;
  localparam logic [7:0]  IDX_FBD_HI  = 8'h3C;
  localparam logic [7:0]  IDX_REF_LO  = 8'h3D;
  localparam logic [7:0]  IDX_REF_HI  = 8'h3E;
  localparam logic [7:0]  IDX_MUL     = 8'h3F;
  // Index given to anything outside the map window or not a word
  localparam logic [7:0]  IDX_NONE    = 8'hFF;
  // Bus geometry
  localparam int          IDX_W       = 8;
  localparam int          IDX_LSB     = 2;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;
  // Control word field positions
  localparam int          CTRL_UPD    = 6;
  localparam int          CTRL_TRIPLE = 5;
  // Field widths
  localparam int          BW_W        = 6;
  localparam int          MUL_W       = 3;
  // Reset values
  localparam logic [31:0] WORD_RST    = 32'h0;
  localparam logic [5:0]  BW_RST      = 6'h0;
  localparam logic [2:0]  MUL_RST     = 3'h0;
  // Bus front-end phases
  typedef enum logic [1:0] {FE_IDLE, FE_WR, FE_RD_WAIT, FE_RD_DONE} acs_fe_st_t;
  // Bus front-end state
  typedef struct packed {
    acs_fe_st_t       st;
    logic [IDX_W-1:0] idx;
  } acs_fe_t;
  // Register file state
  typedef struct packed {
    logic [31:0]      num;
    logic [31:0]      den;
    logic [31:0]      anum;
    logic [31:0]      aden;
    logic [31:0]      fbd;
    logic [31:0]      refd;
    logic [BW_W-1:0]  bwl;
    logic [BW_W-1:0]  bwu;
    logic [MUL_W-1:0] mul;
    logic             upd;
    logic             upd_d;
    logic             trip;
    logic             ld;
    logic             init;
    logic [31:0]      rdat;
  } acs_regs_t;
endpackage

/* File: rtl/acs_regs.sv */
// Audio clock synthesizer and audio genlock parameter registers
//
// Contract
// - Nonzero numerator sets audio ratio numerator
// - Numerator low half first, high next
// - Nonzero denominator sets audio ratio denominator
// - Denominator low half first, high next
// - Ratio defaults follow selected audio rate
// - Bandwidth fields steer loop, defaults follow fs
// - Feedback divider is genlock numerator, split halves
// - Reference divider is genlock denominator, split halves
// - Divider defaults follow selected video standard
// - Three-bit output multiple selector, resets zero
// - Update rising edge loads nonzero ratio parts
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module acs_regs
  import acs_pkg::*;
(
  // Clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  // AHB-Lite slave
  input  wire logic              i_hsel,
  input  wire logic [31:0]       i_haddr,
  input  wire logic [1:0]        i_htrans,
  input  wire logic              i_hwrite,
  input  wire logic [2:0]        i_hsize,
  input  wire logic [31:0]       i_hwdata,
  input  wire logic              i_hready,
  output logic                   o_hreadyout,
  output logic                   o_hresp,
  output logic [31:0]            o_hrdata,
  // Defaults from current rate and standard selection
  input  wire logic [31:0]       i_dflt_num,
  input  wire logic [31:0]       i_dflt_den,
  input  wire logic [BW_W-1:0]   i_dflt_bw_lower,
  input  wire logic [BW_W-1:0]   i_dflt_bw_upper,
  input  wire logic [31:0]       i_dflt_fb_div,
  input  wire logic [31:0]       i_dflt_ref_div,
  // Applied audio ratio to the synthesizer
  output logic [31:0]            o_ratio_num,
  output logic [31:0]            o_ratio_den,
  output logic                   o_ratio_load,
  // Audio genlock loop controls
  output logic [BW_W-1:0]        o_loop_bw_lower,
  output logic [BW_W-1:0]        o_loop_bw_upper,
  output logic [31:0]            o_lock_fb_div,
  output logic [31:0]            o_lock_ref_div,
  // First audio clock output controls
  output logic [MUL_W-1:0]       o_out1_rate_multiple,
  output logic                   o_triple_rate_enable
);

  // Registered and next state
  acs_regs_t        st_reg;
  acs_regs_t        st_next;
  // Write strobe from the front end
  logic             wr_en;
  // Read strobe from the front end
  logic             rd_en;
  // Decoded word index
  logic [IDX_W-1:0] idx;
  // Low half of write data
  logic [15:0]      wd;
  // Rising edge of the update bit
  logic             upd_edge;
  // Read mux result
  logic [31:0]      rdv;

  // Merge one 16-bit half into a 32-bit parameter
  function automatic logic [31:0] put_half(input logic [31:0] old,
                                           input logic        hi,
                                           input logic [15:0] d);
    put_half = hi ? {d, old[15:0]} : {old[31:16], d};
  endfunction

  // Bus phase tracking and wait state
  acs_ahb_front u_front (
    .i_mclk      (i_mclk),
    .i_rst_n     (i_rst_n),
    .i_hsel      (i_hsel),
    .i_haddr     (i_haddr),
    .i_htrans    (i_htrans),
    .i_hwrite    (i_hwrite),
    .i_hsize     (i_hsize),
    .i_hready    (i_hready),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_wr_en     (wr_en),
    .o_rd_en     (rd_en),
    .o_idx       (idx)
  );

  // Next-state logic for every register field
  always_comb begin
    st_next  = st_reg;
    wd       = i_hwdata[15:0];
    rdv      = 32'h0;
    // Edge, not level: a held bit must not keep reloading
    upd_edge = st_reg.upd & ~st_reg.upd_d;
    st_next.upd_d = st_reg.upd;
    st_next.ld    = 1'b0;
    st_next.init  = 1'b0;

    if (st_reg.init) begin
      // First cycle after reset: take selection-dependent defaults
      // An async reset may only load constants, so this waits a clock
      st_next.num  = i_dflt_num;
      st_next.den  = i_dflt_den;
      st_next.anum = i_dflt_num;
      st_next.aden = i_dflt_den;
      st_next.bwl  = i_dflt_bw_lower;
      st_next.bwu  = i_dflt_bw_upper;
      st_next.fbd  = i_dflt_fb_div;
      st_next.refd = i_dflt_ref_div;
    end else if (wr_en) begin
      // Register writes; unused upper bits are dropped
      case (idx)
        IDX_CTRL: begin
          st_next.upd  = i_hwdata[CTRL_UPD];
          st_next.trip = i_hwdata[CTRL_TRIPLE];
        end
        IDX_NUM_LO: begin
          st_next.num = put_half(st_reg.num, 1'b0, wd);
        end
        IDX_NUM_HI: begin
          st_next.num = put_half(st_reg.num, 1'b1, wd);
        end
        IDX_DEN_LO: begin
          st_next.den = put_half(st_reg.den, 1'b0, wd);
        end
        IDX_DEN_HI: begin
          st_next.den = put_half(st_reg.den, 1'b1, wd);
        end
        IDX_BW_LO: begin
          // Range is the host's duty; stored as written
          st_next.bwl = wd[BW_W-1:0];
        end
        IDX_BW_HI: begin
          st_next.bwu = wd[BW_W-1:0];
        end
        IDX_FBD_LO: begin
          st_next.fbd = put_half(st_reg.fbd, 1'b0, wd);
        end
        IDX_FBD_HI: begin
          st_next.fbd = put_half(st_reg.fbd, 1'b1, wd);
        end
        IDX_REF_LO: begin
          st_next.refd = put_half(st_reg.refd, 1'b0, wd);
        end
        IDX_REF_HI: begin
          st_next.refd = put_half(st_reg.refd, 1'b1, wd);
        end
        IDX_MUL: begin
          st_next.mul = wd[MUL_W-1:0];
        end
        default: begin
          // Unmapped write is ignored
        end
      endcase
    end

    // Apply staged ratio; zero parts keep the running value
    if (upd_edge) begin
      st_next.ld = 1'b1;
      if (st_reg.num != 32'h0) begin
        st_next.anum = st_reg.num;
      end
      if (st_reg.den != 32'h0) begin
        st_next.aden = st_reg.den;
      end
    end

    // Read mux; captured in the wait cycle
    case (idx)
      IDX_CTRL: begin
        rdv[CTRL_UPD]    = st_reg.upd;
        rdv[CTRL_TRIPLE] = st_reg.trip;
      end
      IDX_NUM_LO: begin
        rdv = {16'h0, st_reg.num[15:0]};
      end
      IDX_NUM_HI: begin
        rdv = {16'h0, st_reg.num[31:16]};
      end
      IDX_DEN_LO: begin
        rdv = {16'h0, st_reg.den[15:0]};
      end
      IDX_DEN_HI: begin
        rdv = {16'h0, st_reg.den[31:16]};
      end
      IDX_BW_LO: begin
        rdv = 32'(st_reg.bwl);
      end
      IDX_BW_HI: begin
        rdv = 32'(st_reg.bwu);
      end
      IDX_FBD_LO: begin
        rdv = {16'h0, st_reg.fbd[15:0]};
      end
      IDX_FBD_HI: begin
        rdv = {16'h0, st_reg.fbd[31:16]};
      end
      IDX_REF_LO: begin
        rdv = {16'h0, st_reg.refd[15:0]};
      end
      IDX_REF_HI: begin
        rdv = {16'h0, st_reg.refd[31:16]};
      end
      IDX_MUL: begin
        rdv = 32'(st_reg.mul);
      end
      default: begin
        // Unmapped reads return zero
        rdv = 32'h0;
      end
    endcase
    if (rd_en) begin
      st_next.rdat = rdv;
    end
  end

  // State register; defaults arrive one clock after release
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg       <= '0;
      st_reg.num   <= WORD_RST;
      st_reg.den   <= WORD_RST;
      st_reg.anum  <= WORD_RST;
      st_reg.aden  <= WORD_RST;
      st_reg.fbd   <= WORD_RST;
      st_reg.refd  <= WORD_RST;
      st_reg.bwl   <= BW_RST;
      st_reg.bwu   <= BW_RST;
      st_reg.mul   <= MUL_RST;
      st_reg.init  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign o_hrdata             = st_reg.rdat;
  assign o_ratio_num          = st_reg.anum;
  assign o_ratio_den          = st_reg.aden;
  assign o_ratio_load         = st_reg.ld;
  assign o_loop_bw_lower      = st_reg.bwl;
  assign o_loop_bw_upper      = st_reg.bwu;
  assign o_lock_fb_div        = st_reg.fbd;
  assign o_lock_ref_div       = st_reg.refd;
  assign o_out1_rate_multiple = st_reg.mul;
  assign o_triple_rate_enable = st_reg.trip;

  // Applied ratio frozen between update edges
  ratio_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!st_reg.init && !upd_edge) |=> ($stable(o_ratio_num) && $stable(o_ratio_den)))
    else $error("applied ratio changed without update edge");

  // Nonzero numerator applied after edge
  num_apply_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (upd_edge && st_reg.num != 32'h0) |=> (o_ratio_num == $past(st_reg.num)) && o_ratio_load)
    else $error("numerator not applied on update edge");

  // Nonzero denominator applied after edge
  den_apply_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (upd_edge && st_reg.den != 32'h0) |=> (o_ratio_den == $past(st_reg.den)))
    else $error("denominator not applied on update edge");

  // Both parts zero leave running ratio alone
  zero_skip_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (upd_edge && st_reg.num == 32'h0 && st_reg.den == 32'h0) |=> $stable(o_ratio_num) && $stable(o_ratio_den))
    else $error("zero ratio part was applied");

  // Numerator high half lands in bits 31 to 16
  num_half_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_en && !st_reg.init && idx == IDX_NUM_HI) |=> (st_reg.num[31:16] == $past(i_hwdata[15:0]))
      && $stable(st_reg.num[15:0]))
    else $error("numerator high half misplaced");

  // Denominator low half lands in bits 15 to 0
  den_half_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_en && !st_reg.init && idx == IDX_DEN_LO) |=> (st_reg.den[15:0] == $past(i_hwdata[15:0]))
      && $stable(st_reg.den[31:16]))
    else $error("denominator low half misplaced");

  // Feedback low and reference high halves reach the genlock outputs; writes may come back to back, one write per attempt
  div_half_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (wr_en && !st_reg.init && (idx == IDX_FBD_LO || idx == IDX_REF_HI))
      |=> (($past(idx) == IDX_FBD_LO) ? (o_lock_fb_div[15:0] == $past(i_hwdata[15:0]))
                                      : (o_lock_ref_div[31:16] == $past(i_hwdata[15:0]))))
    else $error("divider half not on genlock outputs");

  // Selection defaults taken one clock after release
  dflt_take_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_reg.init && i_rst_n) |=> (o_ratio_num == $past(i_dflt_num)) && (o_lock_fb_div == $past(i_dflt_fb_div))
      && (o_loop_bw_upper == $past(i_dflt_bw_upper)) && !st_reg.init)
    else $error("defaults not loaded after reset");

  // Selector zero at release and still zero one clock later
  mul_reset_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_reg.init |-> (o_out1_rate_multiple == MUL_RST) ##1 (o_out1_rate_multiple == MUL_RST))
    else $error("output multiple not zero after reset");

endmodule // acs_regs
